// [pkg/cmd_src_pkg.sv]
// package: constants, types and register map for command source and timeout
package cmd_src_pkg;

    // =========================================================
    // register byte offsets on the wishbone slave
    localparam logic [7:0] OFS_CMD_SOURCE   = 8'h00; // command_source_selector
    localparam logic [7:0] OFS_IN_FUNC_BASE = 8'h04; // inputN function selectors
    localparam logic [7:0] OFS_PD_TIMEOUT   = 8'h24; // process_data_timeout_setting
    localparam logic [7:0] OFS_MAX_RESP     = 8'h28; // max_response_time_setting
    localparam logic [7:0] OFS_STATUS       = 8'h2C; // sticky events, w1c
    localparam logic [7:0] OFS_MASK         = 8'h30; // interrupt mask
    localparam logic [7:0] OFS_STATE        = 8'h34; // live state, read only
    localparam logic [7:0] OFS_FB_CMD       = 8'h38; // fieldbus run/reverse

    // =========================================================
    // selector codes and reset values
    localparam logic [7:0]  SRC_DIGITAL     = 8'h02;
    localparam logic [7:0]  SRC_FIELDBUS    = 8'h06;
    localparam logic [7:0]  FUNC_RUN        = 8'h01;
    localparam logic [7:0]  FUNC_REVERSE    = 8'h0C;
    localparam logic [7:0]  FUNC_NONE       = 8'h00;
    localparam logic [15:0] PD_TIMEOUT_DEF  = 16'h0064; // 100 ms
    localparam logic [15:0] MAX_RESP_DEF    = 16'h0064; // ms, plain default
    localparam logic [15:0] PD_TIMEOUT_OFF  = 16'h0000;

    // process-data holding registers counting as activity
    localparam logic [15:0] PD_REG_A = 16'd40100;
    localparam logic [15:0] PD_REG_B = 16'd40101;
    localparam logic [15:0] PD_REG_C = 16'd40110;
    localparam logic [15:0] PD_REG_D = 16'd40111;

    // =========================================================
    // timing
    localparam int CLK_HZ     = 40_000_000;
    localparam int TICK_US    = 1000;                       // 1 ms tick
    localparam int TICK_CYC   = CLK_HZ / 1_000_000 * TICK_US;

    // =========================================================
    // status bits
    localparam int ST_TIMEOUT = 0; // setpoint_timeout_fault raised
    localparam int ST_CMD_CHG = 1; // motor command changed
    localparam int ST_BAD_REQ = 2; // corrupted request dropped
    localparam int ST_W       = 3;

    // motor command out of the source selection
    typedef enum logic [2:0] {
        CMD_STOP    = 3'b001, // ramp_stop_command
        CMD_FORWARD = 3'b010,
        CMD_REVERSE = 3'b100
    } motor_cmd_t;

    // one decoded bus request from the serial link
    typedef struct packed {
        logic        valid;    // one-cycle strobe
        logic        bad;      // parity or crc error
        logic [15:0] reg_addr; // holding register number
    } bus_req_t;

endpackage

// [core/pd_watchdog.sv]
// process-data watchdog: ms tick divider and timeout counter
`timescale 1ns/1ps
module pd_watchdog
    import cmd_src_pkg::*;
#(
    parameter int TICK_CYCLES = TICK_CYC // cycles per ms, shorten in sim
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic [15:0] period_i,   // ms, zero disables
    input  wire logic        restart_i,  // valid process-data access
    output logic             expire_o    // one-cycle pulse
);
    import cmd_src_pkg::*;

    localparam int TW = $clog2(TICK_CYCLES + 1);

    logic [TW-1:0] div_r;   // ms prescaler
    logic [15:0]   ms_r;    // elapsed ms since last access
    logic          fired_r; // stay quiet until next access
    logic          tick;
    logic          enabled;

    assign tick    = (div_r == TW'(TICK_CYCLES - 1));
    assign enabled = (period_i != PD_TIMEOUT_OFF);

    // =========================================================
    // prescaler, restarted with each access so each window from an access is full
    always_ff @(posedge clk_i) begin
        if (rst_i || restart_i || tick) begin
            div_r <= '0;
        end else begin
            div_r <= div_r + TW'(1);
        end
    end

    // =========================================================
    // ms counter; idle while disabled so enabling starts fresh
    always_ff @(posedge clk_i) begin
        if (rst_i || restart_i || !enabled) begin
            ms_r    <= '0;
            fired_r <= 1'b0;
            expire_o <= 1'b0;
        end else begin
            expire_o <= 1'b0;
            if (tick && !fired_r) begin
                if (ms_r + 16'd1 >= period_i) begin
                    fired_r  <= 1'b1;
                    expire_o <= 1'b1;
                end
                ms_r <= ms_r + 16'd1;
            end
        end
    end

    // no raise while disabled
    property p_no_fire_off;
        @(posedge clk_i) disable iff (rst_i)
        !enabled |=> !expire_o;
    endproperty
    a_no_fire_off: assert property (p_no_fire_off)
        else $error("watchdog fired while disabled");

    // restart clears the counter
    property p_restart_clear;
        @(posedge clk_i) disable iff (rst_i)
        restart_i |=> (ms_r == 16'd0) && !expire_o;
    endproperty
    a_restart_clear: assert property (p_restart_clear)
        else $error("restart did not clear counter");

endmodule

// [core/cmd_source.sv]
// command source selection, two-wire input decode and setpoint timeout
//
// Functional notes
// - fault when no process access within period
// - only 40100/40101/40110/40111 count as activity
// - parameter registers ignored by the watchdog
// - timeout period resets to 100 ms
// - response time setting matches master's wait
// - run low gives ramp stop
// - run high: forward, or reverse if set
// - selector 2 picks digital inputs
// - function code 1 marks run input
// - function code 12 marks reverse input
// - exactly one command interface active; unknown selector codes leave neither active and the motor stops
// - selector 6 picks fieldbus, default here
// - corrupted request gets no reply
//
// Local design decisions: register access over Wishbone and the placing of the registers.
`timescale 1ns/1ps
module cmd_source
    import cmd_src_pkg::*;
#(
    parameter int N_INPUTS    = 6,        // digital inputs
    parameter int TICK_CYCLES = TICK_CYC  // cycles per ms
) (
    input  wire logic                  clk_i,
    input  wire logic                  rst_i,
    // wishbone classic slave
    input  wire logic                  wb_cyc_i,
    input  wire logic                  wb_stb_i,
    input  wire logic                  wb_we_i,
    input  wire logic [7:0]            wb_adr_i,
    input  wire logic [3:0]            wb_sel_i,
    input  wire logic [31:0]           wb_dat_i,
    output logic      [31:0]           wb_dat_o,
    output logic                       wb_ack_o,
    // serial link decoded requests
    input  wire cmd_src_pkg::bus_req_t link_req_i,
    output logic                       reply_en_o,
    // digital input pins
    input  wire logic [N_INPUTS-1:0]   din_i,
    // toward setpoint path
    output cmd_src_pkg::motor_cmd_t    motor_cmd_o,
    output logic                       setpoint_timeout_fault_o,
    output logic [15:0]                max_response_time_setting_o,
    output logic                       irq_o
);
    import cmd_src_pkg::*;

    // =========================================================
    // register state
    logic [7:0]  command_source_selector_r;
    logic [7:0]  func_sel_r [N_INPUTS];   // per-input function code
    logic [15:0] process_data_timeout_setting_r;
    logic [15:0] max_response_time_setting_r;
    logic [ST_W-1:0] status_r;
    logic [ST_W-1:0] mask_r;
    logic [1:0]  fb_cmd_r;                // [0] run, [1] reverse
    logic        fault_r;                 // live fault level
    logic [31:0] rdata_r;
    logic        ack_r;

    // =========================================================
    // pin synchroniser, first stage read only by second
    logic [N_INPUTS-1:0] din_s1_r;
    logic [N_INPUTS-1:0] din_s2_r;

    always_ff @(posedge clk_i) begin
        din_s1_r <= din_i;
        din_s2_r <= din_s1_r;
    end

    // =========================================================
    // bus decode
    logic       req;
    logic       wr;
    logic       hit_src, hit_to, hit_mr, hit_st, hit_mk, hit_state, hit_fb;
    logic       hit_fn;
    logic [7:0] fn_idx;

    assign req       = wb_cyc_i && wb_stb_i && !ack_r;
    assign wr        = req && wb_we_i && wb_sel_i[0];
    assign hit_src   = (wb_adr_i == OFS_CMD_SOURCE);
    assign hit_to    = (wb_adr_i == OFS_PD_TIMEOUT);
    assign hit_mr    = (wb_adr_i == OFS_MAX_RESP);
    assign hit_st    = (wb_adr_i == OFS_STATUS);
    assign hit_mk    = (wb_adr_i == OFS_MASK);
    assign hit_state = (wb_adr_i == OFS_STATE);
    assign hit_fb    = (wb_adr_i == OFS_FB_CMD);
    assign fn_idx    = 8'((wb_adr_i - OFS_IN_FUNC_BASE) >> 2);
    assign hit_fn    = (wb_adr_i >= OFS_IN_FUNC_BASE)
                    && (fn_idx < 8'(N_INPUTS))
                    && (wb_adr_i[1:0] == 2'b00);

    // =========================================================
    // two-wire decode: any input coded run / reverse
    function automatic logic any_func(input logic [7:0] code);
        logic r;
        r = 1'b0;
        for (int i = 0; i < N_INPUTS; i++) begin
            if (func_sel_r[i] == code && din_s2_r[i]) begin
                r = 1'b1;
            end
        end
        return r;
    endfunction

    logic din_run, din_rev, sel_run, sel_rev, use_din;
    motor_cmd_t cmd_nxt;

    assign din_run = any_func(FUNC_RUN);
    assign din_rev = any_func(FUNC_REVERSE);
    assign use_din = (command_source_selector_r == SRC_DIGITAL);
    // one interface at a time; unknown selector codes stop the motor
    assign sel_run = use_din ? din_run :
                     (command_source_selector_r == SRC_FIELDBUS)
                     ? fb_cmd_r[0] : 1'b0;
    assign sel_rev = use_din ? din_rev : fb_cmd_r[1];
    assign cmd_nxt = !sel_run ? CMD_STOP :
                     (sel_rev ? CMD_REVERSE : CMD_FORWARD);

    // =========================================================
    // link request classification
    logic pd_hit, good_req, expire;

    assign pd_hit   = (link_req_i.reg_addr == PD_REG_A)
                   || (link_req_i.reg_addr == PD_REG_B)
                   || (link_req_i.reg_addr == PD_REG_C)
                   || (link_req_i.reg_addr == PD_REG_D);
    assign good_req = link_req_i.valid && !link_req_i.bad;
    // silence keeps the master waiting so it may time out
    assign reply_en_o = good_req;

    pd_watchdog #(
        .TICK_CYCLES(TICK_CYCLES)
    ) u_wd (
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .period_i  (process_data_timeout_setting_r),
        .restart_i (good_req && pd_hit),
        .expire_o  (expire)
    );

    // =========================================================
    // events, set wins over a same-cycle clear
    logic [ST_W-1:0] ev;
    logic [ST_W-1:0] w1c;

    assign ev[ST_TIMEOUT] = expire;
    assign ev[ST_CMD_CHG] = (cmd_nxt != motor_cmd_o);
    assign ev[ST_BAD_REQ] = link_req_i.valid && link_req_i.bad;
    assign w1c = (wr && hit_st) ? wb_dat_i[ST_W-1:0] : '0;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            status_r <= '0;
        end else begin
            status_r <= (status_r & ~w1c) | ev;
        end
    end

    assign irq_o = |(status_r & mask_r);

    // =========================================================
    // fault level: held until next valid process access
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            fault_r <= 1'b0;
        end else if (expire) begin
            fault_r <= 1'b1;
        end else if (good_req && pd_hit) begin
            fault_r <= 1'b0;
        end
    end

    assign setpoint_timeout_fault_o = fault_r;

    // =========================================================
    // motor command register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            motor_cmd_o <= CMD_STOP;
        end else begin
            motor_cmd_o <= cmd_nxt;
        end
    end

    // =========================================================
    // control register writes
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            command_source_selector_r      <= SRC_FIELDBUS;
            process_data_timeout_setting_r <= PD_TIMEOUT_DEF;
            max_response_time_setting_r    <= MAX_RESP_DEF;
            mask_r   <= '0;
            fb_cmd_r <= '0;
        end else if (wr) begin
            if (hit_src) begin
                command_source_selector_r <= wb_dat_i[7:0];
            end else if (hit_to) begin
                process_data_timeout_setting_r <= wb_dat_i[15:0];
            end else if (hit_mr) begin
                max_response_time_setting_r <= wb_dat_i[15:0];
            end else if (hit_mk) begin
                mask_r <= wb_dat_i[ST_W-1:0];
            end else if (hit_fb) begin
                fb_cmd_r <= wb_dat_i[1:0];
            end
        end
    end

    // the link slave uses this as its own reply deadline
    assign max_response_time_setting_o = max_response_time_setting_r;

    // function selectors: input 0 run, input 1 reverse by default
    generate
        for (genvar g = 0; g < N_INPUTS; g++) begin : g_fn
            localparam logic [7:0] DEF = (g == 0) ? FUNC_RUN :
                                         (g == 1) ? FUNC_REVERSE :
                                         FUNC_NONE;
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    func_sel_r[g] <= DEF;
                end else if (wr && hit_fn && fn_idx == 8'(g)) begin
                    func_sel_r[g] <= wb_dat_i[7:0];
                end
            end
        end
    endgenerate

    // =========================================================
    // read mux; unmapped reads give zero, still acked
    logic [31:0] rd_nxt;

    assign rd_nxt =
        hit_src   ? {24'h000000, command_source_selector_r} :
        hit_fn    ? {24'h000000, func_sel_r[fn_idx[$clog2(N_INPUTS)-1:0]]} :
        hit_to    ? {16'h0000, process_data_timeout_setting_r} :
        hit_mr    ? {16'h0000, max_response_time_setting_r} :
        hit_st    ? {29'h0, status_r} :
        hit_mk    ? {29'h0, mask_r} :
        hit_state ? {26'h0, fault_r, motor_cmd_o, sel_rev, sel_run} :
        hit_fb    ? {30'h0, fb_cmd_r} :
        32'h00000000;

    // one-cycle ack, dropped in the following cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_r   <= 1'b0;
            rdata_r <= '0;
        end else begin
            ack_r   <= req;
            rdata_r <= req ? rd_nxt : rdata_r;
        end
    end

    assign wb_ack_o = ack_r;
    assign wb_dat_o = rdata_r;

    // =========================================================
    // checks
    property p_stop_no_run;
        @(posedge clk_i) disable iff (rst_i)
        !sel_run |=> motor_cmd_o == CMD_STOP;
    endproperty
    a_stop_no_run: assert property (p_stop_no_run)
        else $error("run low did not stop");

    property p_dir;
        @(posedge clk_i) disable iff (rst_i)
        sel_run |=> motor_cmd_o == ($past(sel_rev) ? CMD_REVERSE
                                                   : CMD_FORWARD);
    endproperty
    a_dir: assert property (p_dir)
        else $error("wrong run direction");

    // pins, not the mux wires, must reach the motor command
    property p_din_src;
        @(posedge clk_i) disable iff (rst_i)
        use_din |=> motor_cmd_o == (!$past(din_run) ? CMD_STOP :
                                    $past(din_rev)  ? CMD_REVERSE :
                                                      CMD_FORWARD);
    endproperty
    a_din_src: assert property (p_din_src)
        else $error("digital source not followed");

    // under fieldbus control the pins must have no say at all
    property p_fb_src;
        @(posedge clk_i) disable iff (rst_i)
        (command_source_selector_r == SRC_FIELDBUS)
        |=> motor_cmd_o == (!$past(fb_cmd_r[0]) ? CMD_STOP :
                            $past(fb_cmd_r[1])  ? CMD_REVERSE :
                                                  CMD_FORWARD);
    endproperty
    a_fb_src: assert property (p_fb_src)
        else $error("fieldbus source not followed");

    property p_no_reply_bad;
        @(posedge clk_i) disable iff (rst_i)
        link_req_i.bad |-> !reply_en_o;
    endproperty
    a_no_reply_bad: assert property (p_no_reply_bad)
        else $error("reply to corrupted request");

    property p_fault_set;
        @(posedge clk_i) disable iff (rst_i)
        expire |=> fault_r && status_r[ST_TIMEOUT];
    endproperty
    a_fault_set: assert property (p_fault_set)
        else $error("timeout not flagged");

    property p_pd_clear;
        @(posedge clk_i) disable iff (rst_i)
        (good_req && pd_hit && !expire) |=> !fault_r;
    endproperty
    a_pd_clear: assert property (p_pd_clear)
        else $error("process access did not clear fault");

    property p_param_keep;
        @(posedge clk_i) disable iff (rst_i)
        (good_req && !pd_hit && fault_r) |=> fault_r;
    endproperty
    a_param_keep: assert property (p_param_keep)
        else $error("parameter access cleared fault");

    property p_ack_drop;
        @(posedge clk_i) disable iff (rst_i)
        wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ack_drop: assert property (p_ack_drop)
        else $error("ack held two cycles");

    c_fault:   cover property (@(posedge clk_i) $rose(fault_r));
    c_reverse: cover property (@(posedge clk_i) motor_cmd_o == CMD_REVERSE);
    c_bad:     cover property (@(posedge clk_i) ev[ST_BAD_REQ]);
    c_irq:     cover property (@(posedge clk_i) irq_o);

endmodule

// [testbench/link_master.sv]
// behavioural serial-bus master handing decoded requests to the block
`timescale 1ns/1ps
module link_master
    import cmd_src_pkg::*;
(
    input  wire logic                  clk_i,
    input  wire logic                  reply_en_i,
    output cmd_src_pkg::bus_req_t      req_o
);
    // =========================================================
    // request driver
    // idle between requests: valid low, fields show the inverse of the last
    initial begin
        req_o = '{valid: 1'b0, bad: 1'b0, reg_addr: 16'h0000};
    end

    // one request, one cycle wide; bad marks a parity or crc fault
    task automatic send(input logic [15:0] addr,
                        input logic bad,
                        output logic replied);
        @(posedge clk_i);
        req_o <= '{valid: 1'b1, bad: bad, reg_addr: addr};
        @(posedge clk_i);
        // reply permission is looked at in the request's own cycle
        replied = reply_en_i;
        req_o <= '{valid: 1'b0, bad: ~bad, reg_addr: ~addr};
    endtask
endmodule

// [testbench/command_source_and_bus_timeout_tb.sv]
// self-checking bench for command source selection and setpoint timeout
`timescale 1ns/1ps
module command_source_and_bus_timeout_tb;
    import cmd_src_pkg::*;
    // =========================================================
    // signals and settings
    localparam int          TK  = 4;        // short ms tick for sim
    localparam logic [15:0] PER = 16'h0005; // timeout period in ms
    logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, r;
    logic [7:0]  wb_adr_i;
    logic [3:0]  wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o, q_exp[$];
    logic        wb_ack_o, reply_en_o, fault, irq_o;
    logic [5:0]  din_i;
    logic [15:0] max_resp;
    bus_req_t    link_req;
    motor_cmd_t  motor_cmd_o;
    int          num_errors = 0;
    int          n_compared = 0;
    int          n;
    logic [15:0] pd_addr [4] = '{PD_REG_A, PD_REG_B, PD_REG_C, PD_REG_D};

    cmd_source #(.N_INPUTS(6), .TICK_CYCLES(TK)) dut (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .link_req_i(link_req),
        .reply_en_o(reply_en_o), .din_i(din_i),
        .motor_cmd_o(motor_cmd_o), .setpoint_timeout_fault_o(fault),
        .max_response_time_setting_o(max_resp), .irq_o(irq_o));

    link_master link (.clk_i(clk_i), .reply_en_i(reply_en_o),
                      .req_o(link_req));

    // =========================================================
    // clock, report and compare
    initial begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end

    task automatic end_of_test;
        $display("compared %0d, mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // four-state compare so an unknown never matches
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h",
                     $time, got, exp);
        end
    endtask

    // classic single cycle; reads leave their expectation in the queue
    task automatic wb(input logic [7:0] a, input logic we,
                      input logic [31:0] d, input logic [31:0] exp);
        int k;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        wb_sel_i <= 4'hF;
        if (!we) begin
            q_exp.push_back(exp);
        end
        k = 0;
        do begin
            @(posedge clk_i);
            k++;
        end while (wb_ack_o !== 1'b1 && k < 50);
        if (k >= 50) begin
            num_errors++;
        end
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask

    // read data taken at the acknowledging edge against the oldest note
    always @(posedge clk_i) begin
        if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && q_exp.size() > 0) begin
            chk(wb_dat_o, q_exp.pop_front());
        end
    end

    // hang guard: whole run is well under this span
    initial begin
        repeat (20000) @(posedge clk_i);
        num_errors++;
        end_of_test();
    end

    function automatic logic [31:0] want(input logic run, input logic rev);
        return {29'h0, !run ? CMD_STOP : (rev ? CMD_REVERSE : CMD_FORWARD)};
    endfunction

    // =========================================================
    // main sequence
    initial begin
        rst_i = 1'b1;
        {wb_cyc_i, wb_stb_i, wb_we_i} = 3'b000;
        wb_adr_i = 8'h00;
        wb_sel_i = 4'h0;
        wb_dat_i = 32'h0;
        din_i = 6'h00;
        void'($urandom(89));
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        // reset values and an unmapped place
        wb(OFS_CMD_SOURCE, 1'b0, 0, {24'h0, SRC_FIELDBUS});
        wb(OFS_IN_FUNC_BASE, 1'b0, 0, {24'h0, FUNC_RUN});
        wb(OFS_IN_FUNC_BASE + 8'h04, 1'b0, 0, {24'h0, FUNC_REVERSE});
        wb(OFS_PD_TIMEOUT, 1'b0, 0, {16'h0, PD_TIMEOUT_DEF});
        wb(OFS_MAX_RESP, 1'b0, 0, {16'h0, MAX_RESP_DEF});
        chk({16'h0, max_resp}, {16'h0, MAX_RESP_DEF});
        wb(8'hFC, 1'b1, $urandom, 0);
        wb(8'hFC, 1'b0, 0, 32'h0);
        // two-wire decode on the digital inputs, spare pins random
        wb(OFS_CMD_SOURCE, 1'b1, {24'h0, SRC_DIGITAL}, 0);
        for (int k = 0; k < 4; k++) begin
            din_i <= {4'($urandom), k[1], k[0]};
            repeat (5) @(posedge clk_i);
            chk({29'h0, motor_cmd_o}, want(k[0], k[1]));
        end
        // run function moved to input 3
        wb(OFS_IN_FUNC_BASE + 8'h0C, 1'b1, {24'h0, FUNC_RUN}, 0);
        wb(OFS_IN_FUNC_BASE, 1'b1, {24'h0, FUNC_NONE}, 0);
        din_i <= 6'b001000;
        repeat (5) @(posedge clk_i);
        chk({29'h0, motor_cmd_o}, want(1'b1, 1'b0));
        din_i <= 6'b000001;
        repeat (5) @(posedge clk_i);
        chk({29'h0, motor_cmd_o}, want(1'b0, 1'b0));
        // fieldbus owns the commands; pins say run forward meanwhile
        wb(OFS_CMD_SOURCE, 1'b1, {24'h0, SRC_FIELDBUS}, 0);
        din_i <= 6'b001000;
        for (int k = 3; k >= 0; k--) begin
            wb(OFS_FB_CMD, 1'b1, k, 0);
            repeat (4) @(posedge clk_i);
            chk({29'h0, motor_cmd_o}, want(k[0], k[1]));
        end
        // an unknown selector code must stop the motor whatever asks
        wb(OFS_FB_CMD, 1'b1, 32'h1, 0);
        wb(OFS_CMD_SOURCE, 1'b1, {24'h0, 8'($urandom_range(5, 3))}, 0);
        repeat (4) @(posedge clk_i);
        chk({29'h0, motor_cmd_o}, want(1'b0, 1'b0));
        wb(OFS_CMD_SOURCE, 1'b1, {24'h0, SRC_FIELDBUS}, 0);
        repeat (4) @(posedge clk_i);
        chk({29'h0, motor_cmd_o}, want(1'b1, 1'b0));
        // setpoint supervision with a short period
        wb(OFS_PD_TIMEOUT, 1'b1, {16'h0, PER}, 0);
        wb(OFS_MASK, 1'b1, 32'h1, 0);
        for (int i = 0; i < 4; i++) begin
            link.send(pd_addr[i], 1'b0, r);
            chk({31'h0, r}, 32'h1);
            repeat (12) @(posedge clk_i);
            chk({31'h0, fault}, 32'h0);
        end
        wb(OFS_STATUS, 1'b1, 32'h7, 0);
        chk({31'h0, irq_o}, 32'h0);
        // parameter traffic and a corrupted request keep nothing alive
        link.send(PD_REG_D, 1'b0, r);
        link.send(16'd40200, 1'b0, r);
        link.send(16'd40522, 1'b0, r);
        link.send(PD_REG_A, 1'b1, r);
        chk({31'h0, r}, 32'h0);
        n = 6;
        while (fault !== 1'b1 && n < 60) begin
            @(posedge clk_i);
            n++;
        end
        chk(n >= PER * TK - 2 && n <= PER * TK + 4, 32'h1);
        @(posedge clk_i);
        chk({31'h0, irq_o}, 32'h1);
        wb(OFS_STATUS, 1'b0, 0, 32'h5);
        wb(OFS_STATUS, 1'b1, 32'h5, 0);
        chk({31'h0, irq_o}, 32'h0);
        // good access clears the fault; zero period never raises it
        link.send(PD_REG_B, 1'b0, r);
        @(posedge clk_i);
        chk({31'h0, fault}, 32'h0);
        wb(OFS_PD_TIMEOUT, 1'b1, 32'h0, 0);
        repeat (100) @(posedge clk_i);
        chk({31'h0, fault}, 32'h0);
        end_of_test();
    end
endmodule
